/* File: rtl/ext_bus_seq.sv */
// Bus-cycle sequencer: latch strobe, ready wait states, recovery cycle.
// Assumes the bus unit presents one request with its space, address and
// data held until done_o pulses.
`timescale 1ns/1ns
`include "ext_bus_consts.svh"
module ext_bus_seq #(
    parameter int AW = 24,
    parameter int DW = 16,
    parameter int CW = 4
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // Configuration.
    input wire logic [7:0] space_wait_control_reg0_i,
    input wire logic [7:0] space_wait_control_reg1_i,
    input wire logic [7:0] space_wait_control_reg2_i,
    input wire logic [7:0] space_wait_control_reg3_i,
    input wire logic [7:0] processor_mode_reg1_i,
    // Request from the bus unit.
    input wire logic req_i,
    input wire logic req_internal_i,
    input wire logic [1:0] req_space_i,
    input wire logic req_write_i,
    input wire logic [AW-1:0] req_addr_i,
    input wire logic [DW-1:0] req_wdata_i,
    input wire logic [CW-1:0] req_cycles_i,
    input wire logic sw_wait_next_i,
    input wire logic hold_acknowledge_n_i,
    input wire logic [7:0] port_out_i,
    output logic done_o,
    // External pins.
    input wire logic ready_n_i,
    output logic [AW-1:0] addr_o,
    output logic [DW-1:0] data_o,
    output logic data_oe_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [3:0] cs_n_o,
    output logic [`EB_NUM_ALE_PINS-1:0] latch_strobe_o,
    output logic hold_acknowledge_n_o,
    output logic [7:0] port_out_o
);
    ext_bus_pkg::bus_state_e state;
    logic ready_n;
    logic [CW-1:0] cnt;
    logic [1:0] space;
    logic internal;
    logic write;
    logic ale;

    ready_sync u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ready_n_i(ready_n_i),
        .ready_n_o(ready_n)
    );

    function automatic logic [7:0] wcr(input logic [1:0] s);
        case (s)
            2'h0: wcr = space_wait_control_reg0_i;
            2'h1: wcr = space_wait_control_reg1_i;
            2'h2: wcr = space_wait_control_reg2_i;
            default: wcr = space_wait_control_reg3_i;
        endcase
    endfunction

    logic [7:0] cfg;
    logic muxed;
    logic recov_en;
    logic last;
    logic [1:0] pin_sel;
    assign cfg = wcr(space);
    assign muxed = !internal && cfg[`EB_MUX_BIT];
    // Recovery is only meaningful on a separate bus.
    assign recov_en = !internal && cfg[`EB_RECOVERY_BIT] &&
                      !muxed;
    assign last = (state == ext_bus_pkg::ST_ACCESS) && (cnt == '0);
    assign pin_sel = {processor_mode_reg1_i[`EB_SEL_HI_BIT],
                      processor_mode_reg1_i[`EB_SEL_LO_BIT]};

    logic wait_take;
    // Ready is not honoured when software waits follow next.
    assign wait_take = last && !ready_n && !sw_wait_next_i;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ext_bus_pkg::ST_IDLE;
            cnt <= '0;
            space <= 2'h0;
            internal <= 1'b0;
            write <= 1'b0;
        end else begin
            case (state)
                ext_bus_pkg::ST_IDLE: begin
                    if (req_i && !done_o) begin
                        space <= req_space_i;
                        internal <= req_internal_i;
                        write <= req_write_i;
                        cnt <= req_cycles_i;
                        state <= ext_bus_pkg::ST_LATCH;
                    end
                end
                ext_bus_pkg::ST_LATCH: begin
                    state <= ext_bus_pkg::ST_ACCESS;
                end
                ext_bus_pkg::ST_ACCESS: begin
                    if (cnt != '0) begin
                        cnt <= cnt - 1'b1;
                    end else if (wait_take) begin
                        state <= ext_bus_pkg::ST_READY_WAIT;
                    end else if (recov_en) begin
                        state <= ext_bus_pkg::ST_RECOVERY;
                    end else begin
                        state <= ext_bus_pkg::ST_IDLE;
                    end
                end
                ext_bus_pkg::ST_READY_WAIT: begin
                    if (ready_n) begin
                        state <= recov_en ? ext_bus_pkg::ST_RECOVERY
                                          : ext_bus_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= ext_bus_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // A low synchronised pin asks for wait states; high lets the cycle run.
    // The synchroniser resets high, so no false stall follows reset.

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (state == ext_bus_pkg::ST_RECOVERY) ||
                      (last && !wait_take && !recov_en) ||
                      (state == ext_bus_pkg::ST_READY_WAIT && ready_n &&
                       !recov_en);
        end
    end

    // Strobe pulses in the latch state for every access.
    assign ale = (state == ext_bus_pkg::ST_LATCH);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_o <= '0;
            data_o <= '0;
            data_oe_o <= 1'b0;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            cs_n_o <= 4'hF;
            latch_strobe_o <= '0;
            hold_acknowledge_n_o <= 1'b1;
            port_out_o <= 8'h00;
        end else if (state == ext_bus_pkg::ST_READY_WAIT) begin
            // Everything frozen while the external device stalls.
            addr_o <= addr_o;
        end else begin
            hold_acknowledge_n_o <= hold_acknowledge_n_i;
            port_out_o <= port_out_i;
            latch_strobe_o <= '0;
            latch_strobe_o[pin_sel] <= ale;
            if (state == ext_bus_pkg::ST_RECOVERY) begin
                // Address and write data persist; strobes released.
                rd_n_o <= 1'b1;
                wr_n_o <= 1'b1;
                cs_n_o <= 4'hF;
            end else if (state == ext_bus_pkg::ST_IDLE) begin
                rd_n_o <= 1'b1;
                wr_n_o <= 1'b1;
                cs_n_o <= 4'hF;
                data_oe_o <= 1'b0;
                if (req_i && !done_o && !req_internal_i) begin
                    addr_o <= req_addr_i;
                end
            end else if (!internal) begin
                cs_n_o <= ~(4'h1 << space);
                rd_n_o <= write;
                wr_n_o <= !write || (state == ext_bus_pkg::ST_LATCH && muxed);
                data_oe_o <= write || (state == ext_bus_pkg::ST_LATCH && muxed);
                data_o <= (state == ext_bus_pkg::ST_LATCH && muxed)
                          ? req_addr_i[DW-1:0] : req_wdata_i;
            end
        end
    end

    AST_WAIT_FREEZE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state == ext_bus_pkg::ST_READY_WAIT &&
        $past(state) == ext_bus_pkg::ST_READY_WAIT |->
        $stable(addr_o) && $stable(rd_n_o) && $stable(wr_n_o) &&
        $stable(cs_n_o) && $stable(data_o) && $stable(port_out_o) &&
        $stable(data_oe_o) && $stable(latch_strobe_o) &&
        $stable(hold_acknowledge_n_o))
        else $error("outputs moved during ready wait");
    AST_WAIT_ENTRY: assert property (@(posedge clk_i) disable iff (!nrst_i)
        last && !ready_n && !sw_wait_next_i |=>
        state == ext_bus_pkg::ST_READY_WAIT)
        else $error("wait not inserted");
    AST_WAIT_EXIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state == ext_bus_pkg::ST_READY_WAIT && ready_n |=>
        state != ext_bus_pkg::ST_READY_WAIT)
        else $error("cycle did not resume");
    AST_SW_IGNORE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        last && sw_wait_next_i |=> state != ext_bus_pkg::ST_READY_WAIT)
        else $error("ready honoured before software waits");
    AST_RECOV: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state == ext_bus_pkg::ST_RECOVERY |=>
        $stable(addr_o) && $stable(data_o) && $stable(data_oe_o))
        else $error("recovery changed address or data");
    AST_RECOV_ADD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        last && !wait_take && recov_en |=> state == ext_bus_pkg::ST_RECOVERY)
        else $error("recovery not appended");
    AST_NO_RECOV: assert property (@(posedge clk_i) disable iff (!nrst_i)
        last && !wait_take && !recov_en |=> state == ext_bus_pkg::ST_IDLE ##1
        !done_o || state != ext_bus_pkg::ST_RECOVERY)
        else $error("extra recovery clock");
    AST_STROBE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state == ext_bus_pkg::ST_LATCH |=> latch_strobe_o[$past(pin_sel)]
        ##1 latch_strobe_o == '0)
        else $error("latch strobe not pulsed");
endmodule // ext_bus_seq

/* File: rtl/ext_bus_consts.svh */
// Constants for the external bus recovery, latch strobe and ready block.
// Assumes a single 100 MHz clock standing in for the bus clock.
// Contract
// - Per-space bit selects recovery cycle append.
// - Recovery holds address, write data; separate only.
// - Pulse latch strobe on multiplexed bus.
// - Two mode bits choose strobe output pin.
// - Strobe issued for internal and external.
// - Ready low at last clock inserts waits.
// - Ready high during wait resumes cycle.
// - Outputs frozen throughout ready wait states.
// - Ready ignored just before software waits.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH
`define EB_RECOVERY_BIT 6
`define EB_MUX_BIT 5
`define EB_SEL_HI_BIT 5
`define EB_SEL_LO_BIT 4
`define EB_NUM_SPACES 4
`define EB_NUM_ALE_PINS 4
`endif

/* File: rtl/ext_bus_pkg.sv */
// Types shared by the external bus block.
// Assumes nothing beyond the constants header.
package ext_bus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LATCH = 3'b001,
        ST_ACCESS = 3'b010,
        ST_READY_WAIT = 3'b011,
        ST_RECOVERY = 3'b100
    } bus_state_e;
endpackage

/* File: rtl/ready_sync.sv */
// Three-stage synchroniser for the external active-low ready pin.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ns
module ready_sync (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // Pin and filtered level.
    input wire logic ready_n_i,
    output logic ready_n_o
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= ready_n_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change is accepted only when the last two stages agree.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_n_o <= 1'b1;
        end else if (s2 == s3) begin
            ready_n_o <= s3;
        end
    end
endmodule // ready_sync

/* File: test/ext_dev_model.sv */
// Parallel-bus device model: an address latch and a slow ready pin.
// Assumes the bench sets stall_len_i before the access that it stalls.
`timescale 1ns/1ns
module ext_dev_model (
    // Clock.
    input wire logic clk_i,
    // Bus pins.
    input wire logic [23:0] addr_i,
    input wire logic [15:0] data_i,
    input wire logic [3:0] strobe_i,
    output logic ready_n_o,
    // Bench side.
    input wire logic mux_i,
    input wire logic [7:0] stall_len_i,
    output logic [15:0] latched_o = 16'h0000,
    output logic [1:0] pin_o = 2'h0,
    output logic [7:0] pulses_o = 8'h00,
    output logic deep_o
);
    logic [7:0] cnt = 8'h00;
    logic seen = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // The latch keeps what the bus carried up to the strobe's falling edge.
    always @(posedge clk_i) begin
        if (|strobe_i) begin
            latched_o <= mux_i ? data_i : addr_i[15:0];
            pin_o <= {strobe_i[3] | strobe_i[2], strobe_i[3] | strobe_i[1]};
            pulses_o <= pulses_o + 8'h01;
        end
        cnt <= |strobe_i ? 8'h01 : cnt + {7'h00, cnt != 8'hFF};
        seen <= (stall_len_i != 8'h00) && (seen || |strobe_i);
    end
    // The pin is held low from arming until enough clocks follow the strobe.
    assign ready_n_o = !(stall_len_i != 8'h00 &&
                         !(seen && cnt >= stall_len_i));
    assign deep_o = !ready_n_o && seen && cnt >= 8'h08;
endmodule // ext_dev_model

/* File: test/external_bus_recovery_ale_wait_test.sv */
// Bench for the bus-cycle sequencer facing a parallel-bus device model.
// Assumes the design and the device model are compiled before it.
`timescale 1ns/1ns
module external_bus_recovery_ale_wait_test;
    typedef struct {
        logic [23:0] addr;
        logic [1:0] pin;
        logic [7:0] pulses;
        logic [15:0] wdata;
        logic [3:0] cs;
        bit wr;
        int lat;
        bit more;
        bit ext;
        bit sep;
    } note_s;
    note_s notes[$];
    note_s cur;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] wcr [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] pm1 = 8'h00, port = 8'h00, stall = 8'h00;
    logic req_i = 1'b0, intl = 1'b0, wr = 1'b0, sw = 1'b0, mux = 1'b0;
    logic hold_n = 1'b1, deep_q = 1'b0;
    logic [1:0] space = 2'h0;
    logic [23:0] addr = 24'h000000;
    logic [15:0] wdata = 16'h0000;
    logic [3:0] cyc = 4'h0;
    logic ready_n, done, oe, rd_n, wr_n, hold_o, deep;
    logic [23:0] addr_o;
    logic [15:0] data_o, latched;
    logic [3:0] cs_n, strobe;
    logic [1:0] pin;
    logic [7:0] port_o, pulses;
    logic [59:0] snap = 60'h0;
    wire [59:0] outs = {addr_o, data_o, oe, rd_n, wr_n, cs_n, strobe, hold_o, port_o};
    int lat = 0;
    int err_count = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////////////////////////////
    ext_bus_seq dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .space_wait_control_reg0_i(wcr[0]), .space_wait_control_reg1_i(wcr[1]),
        .space_wait_control_reg2_i(wcr[2]), .space_wait_control_reg3_i(wcr[3]),
        .processor_mode_reg1_i(pm1), .req_i(req_i), .req_internal_i(intl),
        .req_space_i(space), .req_write_i(wr), .req_addr_i(addr),
        .req_wdata_i(wdata), .req_cycles_i(cyc), .sw_wait_next_i(sw),
        .hold_acknowledge_n_i(hold_n), .port_out_i(port), .done_o(done),
        .ready_n_i(ready_n), .addr_o(addr_o), .data_o(data_o),
        .data_oe_o(oe), .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n),
        .latch_strobe_o(strobe), .hold_acknowledge_n_o(hold_o),
        .port_out_o(port_o));
    ext_dev_model dev (.clk_i(clk_i), .addr_i(addr_o), .data_i(data_o),
        .strobe_i(strobe), .ready_n_o(ready_n), .mux_i(mux),
        .stall_len_i(stall), .latched_o(latched), .pin_o(pin),
        .pulses_o(pulses), .deep_o(deep));
    ////////////////////////////////////////////////////////////////////////
    initial forever #5 clk_i = ~clk_i;
    task automatic conclude();
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic acc(input logic ii, input logic [1:0] sp, input logic rec,
                       input logic m, input logic s, input logic [7:0] st);
        note_s n;
        int k;
        @(posedge clk_i);
        #1;
        {intl, space, mux, sw, stall} = {ii, sp, m, s, st};
        wcr[sp] = {1'b0, rec, m, 5'h00};
        pm1 = {2'h0, 2'($urandom), 4'h0};
        wr = 1'($urandom);
        addr = 24'($urandom);
        wdata = 16'($urandom);
        cyc = 4'($urandom_range(3));
        // A stalling device drives its pin before the request, so that the
        // synchronised level already stands at the last access clock.
        if (st != 8'h00) begin
            repeat (5) @(posedge clk_i);
            #1;
        end
        req_i = 1'b1;
        n.addr = addr;
        n.wr = wr;
        n.wdata = wdata;
        n.cs = (!ii && !(rec && !m)) ? ~(4'h1 << sp) : 4'hF;
        n.pin = pm1[5:4];
        n.pulses = pulses + 8'h01;
        n.lat = 3 + int'(cyc) + int'(rec && !m && !ii);
        n.more = st != 8'h00 && !s;
        n.ext = !ii;
        n.sep = !ii && !m;
        notes.push_back(n);
        for (k = 0; k < 80 && done !== 1'b1; k++) @(negedge clk_i);
        chk(k < 80, "no completion");
        @(posedge clk_i);
        #1;
        {req_i, sw, stall} = {1'b0, 1'b0, 8'h00};
        // The ready synchroniser needs a few clocks to see the pin again.
        if (st != 8'h00) repeat (6) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Side inputs take new random values every clock so that a missed freeze shows.
    always @(posedge clk_i) begin
        #1;
        hold_n <= 1'($urandom);
        port <= 8'($urandom);
    end
    always @(posedge clk_i) lat <= req_i ? lat + 1 : 0;
    always @(negedge clk_i) begin
        deep_q <= deep;
        snap <= outs;
        if (deep && deep_q) chk(snap === outs, "outputs moved in wait");
        if (done === 1'b1 && notes.size() > 0) begin
            cur = notes.pop_front();
            if (cur.more) chk(lat > cur.lat, "cycle not stretched");
            else chk(lat == cur.lat, "cycle length");
            chk(pulses === cur.pulses && pin === cur.pin, "strobe");
            if (cur.ext) chk(latched === cur.addr[15:0], "latched");
            if (cur.sep) chk(addr_o === cur.addr, "address held");
            if (cur.sep && cur.wr)
                chk(data_o === cur.wdata, "write data");
            chk(cs_n === cur.cs, "chip select");
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        conclude();
    end
    initial begin
        void'($urandom(32'hCB1A));
        repeat (4) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        for (int i = 0; i < 16; i++) begin
            acc(1'b0, 2'(i), i[2], i[3], 1'b0, 8'h00);
        end
        acc(1'b1, 2'h1, 1'b1, 1'b0, 1'b0, 8'h00);
        acc(1'b1, 2'h2, 1'b1, 1'b1, 1'b0, 8'h00);
        acc(1'b0, 2'h3, 1'b0, 1'b0, 1'b0, 8'h0C);
        acc(1'b0, 2'h0, 1'b1, 1'b1, 1'b0, 8'h0C);
        acc(1'b0, 2'h2, 1'b0, 1'b0, 1'b1, 8'h0C);
        conclude();
    end
endmodule // external_bus_recovery_ale_wait_test
